// ===== iodr_pkg.sv
// Purpose: Shared constants for the inertial output register block.
// Assumes: 40 MHz system clock, 16-bit register words, byte addressing.
// Notes:   Register offsets are byte addresses; a word index is offset / 2.
package iodr_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [6:0] OFS_ACCEL_X_LOW   = 7'h10;
  localparam logic [6:0] OFS_ACCEL_X_HIGH  = 7'h12;
  localparam logic [6:0] OFS_ACCEL_Y_LOW   = 7'h14;
  localparam logic [6:0] OFS_ACCEL_Y_HIGH  = 7'h16;
  localparam logic [6:0] OFS_ACCEL_Z_LOW   = 7'h18;
  localparam logic [6:0] OFS_ACCEL_Z_HIGH  = 7'h1a;
  localparam logic [6:0] OFS_TEMPERATURE   = 7'h1c;
  localparam logic [6:0] OFS_TIME_STAMP    = 7'h1e;
  localparam logic [6:0] OFS_UPDATE_COUNT  = 7'h22;
  localparam logic [6:0] OFS_DANGLE_X_LOW  = 7'h24;
  localparam logic [6:0] OFS_DANGLE_Y_LOW  = 7'h28;
  localparam logic [6:0] OFS_DANGLE_Z_LOW  = 7'h2c;
  localparam logic [6:0] OFS_DANGLE_STRIDE = 7'h04;
  localparam logic [6:0] OFS_HIGH_STEP     = 7'h02;

  // ************************************************************
  // Field layout and codes
  // ************************************************************
  localparam int          WORD_W           = 16;
  localparam int          MAP_WORDS        = 32;
  localparam int          IDX_W            = 5;
  localparam int          SAMPLE_W         = 32;
  localparam int          FRAME_BITS       = 16;
  localparam int          FRAME_ADDR_MSB   = 13;
  localparam int          FRAME_IDX_MSB    = 12;
  localparam int          FRAME_IDX_LSB    = 8;
  localparam logic [2:0]  SYNC_MODE_SCALED = 3'b010;
  localparam logic [15:0] COUNT_CLEAR      = 16'h0000;
  localparam logic [15:0] COUNT_MAX        = 16'hffff;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_KHZ          = 40000;
  localparam int TS_LSB_PS        = 49020000;
  localparam int TS_LSB_CYCLES    = int'((64'(TS_LSB_PS) * 64'(CLK_KHZ)) / 64'd1000000000);

  typedef logic [MAP_WORDS-1:0][WORD_W-1:0] iodr_map_type;

endpackage

// ===== iodr_snapshot_mem.sv
// Purpose: Holds one coherent snapshot of all output register words.
// Assumes: All words are written together in one cycle.
// Notes:   Read data come from a register, one cycle after the index.
`timescale 1ns/1ps
module iodr_snapshot_mem
  import iodr_pkg::*;
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32,
  parameter int AW    = 5
) (
  input  wire logic                   clk_i,
  input  wire logic                   nrst_i,
  input  wire logic                   ce_i,
  input  wire logic                   load_i,
  input  wire logic [DEPTH*WIDTH-1:0] load_data_i,
  input  wire logic [AW-1:0]          rd_idx_i,
  output logic      [WIDTH-1:0]       rd_data_o
);

  logic [DEPTH*WIDTH-1:0] words;
  logic [DEPTH*WIDTH-1:0] next_words;
  logic [WIDTH-1:0]       next_rd_data;

  always_comb begin
    next_words   = load_i ? load_data_i : words;
    next_rd_data = words[rd_idx_i*WIDTH +: WIDTH];
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      words     <= '0;
      rd_data_o <= '0;
    end else if (ce_i) begin
      words     <= next_words;
      rd_data_o <= next_rd_data;
    end
  end

endmodule

// ===== iodr_output_regs.sv
// Purpose: Output register set of an inertial unit with delta angle integration and serial read port.
// Assumes: Sensor samples arrive in the clk_i domain; serial pins and sync pin are asynchronous.
// Notes:   Serial frames are 16 bits; the word asked for in one frame returns in the next.
`timescale 1ns/1ps

module iodr_output_regs
  import iodr_pkg::*;
#(
  parameter int SW = SAMPLE_W
) (
  input  wire logic          clk_i,
  input  wire logic          nrst_i,
  input  wire logic          ce_i,
  input  wire logic          sample_valid_i,
  input  wire logic [SW-1:0] accel_x_i,
  input  wire logic [SW-1:0] accel_y_i,
  input  wire logic [SW-1:0] accel_z_i,
  input  wire logic [SW-1:0] gyro_x_i,
  input  wire logic [SW-1:0] gyro_y_i,
  input  wire logic [SW-1:0] gyro_z_i,
  input  wire logic [15:0]   temperature_i,
  input  wire logic [15:0]   decimation_value_i,
  input  wire logic [2:0]    sync_mode_i,
  input  wire logic          reset_command_i,
  input  wire logic          sync_pin_i,
  input  wire logic          sclk_i,
  input  wire logic          cs_n_i,
  input  wire logic          mosi_i,
  output logic               miso_o,
  output logic               data_ready_pin_o
);

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic [3:0] pin_meta;
  logic [3:0] pin_sync;
  logic [3:0] pin_last;
  logic [3:0] next_pin_last;

  always_comb begin
    next_pin_last = pin_sync;
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      pin_meta <= 4'hf;
      pin_sync <= 4'hf;
      pin_last <= 4'hf;
    end else if (ce_i) begin
      pin_meta <= {sync_pin_i, sclk_i, cs_n_i, mosi_i};
      pin_sync <= pin_meta;
      pin_last <= next_pin_last;
    end
  end

  logic sync_edge;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;
  assign sync_edge = pin_sync[3] & ~pin_last[3];
  assign sclk_rise = pin_sync[2] & ~pin_last[2];
  assign sclk_fall = ~pin_sync[2] & pin_last[2];
  assign cs_fall   = ~pin_sync[1] & pin_last[1];

  // ************************************************************
  // Integration, time stamp and update control
  // ************************************************************
  function automatic logic [SW:0] pair_sum(input logic [SW:0] acc, input logic [SW-1:0] cur,
                                           input logic [SW-1:0] prev);
    pair_sum = acc + {cur[SW-1], cur} + {prev[SW-1], prev};
  endfunction

  function automatic logic [IDX_W-1:0] widx(input logic [6:0] ofs);
    widx = ofs[IDX_W:1];
  endfunction

  logic [2:0][SW:0]   acc, next_acc;
  logic [2:0][SW-1:0] prev, next_prev;
  logic [2:0][SW-1:0] gyro_now;
  logic [15:0]        samp_cnt, next_samp_cnt;
  logic [15:0]        upd_cnt, next_upd_cnt;
  logic [15:0]        ts_cnt, next_ts_cnt;
  logic [15:0]        ts_div, next_ts_div;
  logic               load, next_load;
  logic               dr, next_dr;
  iodr_map_type       snap, next_snap;

  assign gyro_now = {gyro_z_i, gyro_y_i, gyro_x_i};

  always_comb begin
    logic [2:0][SW:0] sum;
    logic [SW-1:0]    res;
    sum           = '0;
    res           = '0;
    next_acc      = acc;
    next_prev     = prev;
    next_samp_cnt = samp_cnt;
    next_upd_cnt  = upd_cnt;
    next_ts_cnt   = ts_cnt;
    next_ts_div   = ts_div;
    next_load     = 1'b0;
    // Data ready follows the memory load, so a host never reads the previous set after the pin rises.
    next_dr       = load;
    next_snap     = snap;
    // Time stamp restarts at every sync edge and saturates rather than wrap.
    if (sync_mode_i != SYNC_MODE_SCALED) begin
      next_ts_cnt = COUNT_CLEAR;
      next_ts_div = COUNT_CLEAR;
    end else if (sync_edge) begin
      next_ts_cnt = COUNT_CLEAR;
      next_ts_div = COUNT_CLEAR;
    end else if (ts_div == 16'(TS_LSB_CYCLES - 1)) begin
      next_ts_div = COUNT_CLEAR;
      if (ts_cnt != COUNT_MAX) begin
        next_ts_cnt = ts_cnt + 16'h0001;
      end
    end else begin
      next_ts_div = ts_div + 16'h0001;
    end
    if (sample_valid_i) begin
      for (int a = 0; a < 3; a++) begin
        sum[a] = pair_sum(acc[a], gyro_now[a], prev[a]);
      end
      next_prev = gyro_now;
      if (samp_cnt == decimation_value_i) begin
        next_samp_cnt = COUNT_CLEAR;
        next_acc      = '0;
        next_load     = 1'b1;
        next_upd_cnt  = upd_cnt + 16'h0001;
        next_snap[widx(OFS_ACCEL_X_LOW)]  = accel_x_i[15:0];
        next_snap[widx(OFS_ACCEL_X_HIGH)] = accel_x_i[31:16];
        next_snap[widx(OFS_ACCEL_Y_LOW)]  = accel_y_i[15:0];
        next_snap[widx(OFS_ACCEL_Y_HIGH)] = accel_y_i[31:16];
        next_snap[widx(OFS_ACCEL_Z_LOW)]  = accel_z_i[15:0];
        next_snap[widx(OFS_ACCEL_Z_HIGH)] = accel_z_i[31:16];
        next_snap[widx(OFS_TEMPERATURE)]  = temperature_i;
        next_snap[widx(OFS_TIME_STAMP)]   = ts_cnt;
        next_snap[widx(OFS_UPDATE_COUNT)] = next_upd_cnt;
        for (int a = 0; a < 3; a++) begin
          // Dropping the sum's LSB is the one-half factor; the sample rate is folded into the LSB weight.
          res = sum[a][SW:1];
          next_snap[widx(OFS_DANGLE_X_LOW + 7'(a) * OFS_DANGLE_STRIDE)] = res[15:0];
          next_snap[widx(OFS_DANGLE_X_LOW + 7'(a) * OFS_DANGLE_STRIDE + OFS_HIGH_STEP)] = res[31:16];
        end
      end else begin
        next_samp_cnt = samp_cnt + 16'h0001;
        next_acc      = sum;
      end
    end
    if (reset_command_i) begin
      next_upd_cnt  = COUNT_CLEAR;
      next_samp_cnt = COUNT_CLEAR;
      next_acc      = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      acc      <= '0;
      prev     <= '0;
      samp_cnt <= COUNT_CLEAR;
      upd_cnt  <= COUNT_CLEAR;
      ts_cnt   <= COUNT_CLEAR;
      ts_div   <= COUNT_CLEAR;
      load     <= 1'b0;
      dr       <= 1'b0;
      snap     <= '0;
    end else if (ce_i) begin
      acc      <= next_acc;
      prev     <= next_prev;
      samp_cnt <= next_samp_cnt;
      upd_cnt  <= next_upd_cnt;
      ts_cnt   <= next_ts_cnt;
      ts_div   <= next_ts_div;
      load     <= next_load;
      dr       <= next_dr;
      snap     <= next_snap;
    end
  end

  assign data_ready_pin_o = dr;

  // ************************************************************
  // Snapshot memory
  // ************************************************************
  logic [IDX_W-1:0]  rd_idx;
  logic [WORD_W-1:0] rd_data;

  iodr_snapshot_mem #(
    .WIDTH (WORD_W),
    .DEPTH (MAP_WORDS),
    .AW    (IDX_W)
  ) u_mem (
    .clk_i       (clk_i),
    .nrst_i      (nrst_i),
    .ce_i        (ce_i),
    .load_i      (load),
    .load_data_i (snap),
    .rd_idx_i    (rd_idx),
    .rd_data_o   (rd_data)
  );

  // ************************************************************
  // Serial read port
  // ************************************************************
  logic [15:0]      rx, next_rx;
  logic [15:0]      tx, next_tx;
  logic [4:0]       bit_cnt, next_bit_cnt;
  logic [IDX_W-1:0] next_rd_idx;
  logic             rd_hit, next_rd_hit;

  always_comb begin
    next_rx      = rx;
    next_tx      = tx;
    next_bit_cnt = bit_cnt;
    next_rd_idx  = rd_idx;
    next_rd_hit  = rd_hit;
    if (pin_sync[1]) begin
      next_bit_cnt = '0;
    end else if (cs_fall) begin
      // Addresses above the map answer zero instead of aliasing.
      next_tx      = rd_hit ? rd_data : '0;
      next_bit_cnt = '0;
    end else if (sclk_rise) begin
      next_rx      = {rx[14:0], pin_sync[0]};
      next_bit_cnt = bit_cnt + 5'h01;
      if (bit_cnt == 5'(FRAME_BITS - 1)) begin
        next_rd_idx = rx[FRAME_IDX_MSB:FRAME_IDX_LSB];
        next_rd_hit = ~rx[FRAME_ADDR_MSB];
      end
    end else if (sclk_fall) begin
      next_tx = {tx[14:0], 1'b0};
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      rx      <= '0;
      tx      <= '0;
      bit_cnt <= '0;
      rd_idx  <= '0;
      rd_hit  <= 1'b0;
    end else if (ce_i) begin
      rx      <= next_rx;
      tx      <= next_tx;
      bit_cnt <= next_bit_cnt;
      rd_idx  <= next_rd_idx;
      rd_hit  <= next_rd_hit;
    end
  end

  assign miso_o = tx[15];

endmodule

// ===== iodr_props.sv
// Purpose: Port checks of update timing and serial output.
// Assumes: An update raises data ready two cycles after its sample.
// Notes:   Samples are mirrored two cycles late so counts line up.
`timescale 1ns/1ps
module iodr_props (
  input wire logic        clk_i,
  input wire logic        nrst_i,
  input wire logic        ce_i,
  input wire logic        sample_valid_i,
  input wire logic [15:0] decimation_value_i,
  input wire logic        reset_command_i,
  input wire logic        sclk_i,
  input wire logic        cs_n_i,
  input wire logic        miso_o,
  input wire logic        data_ready_pin_o
);
  // ****
  // Helper state and checks
  // ****
  logic        sv1, sv2, rc1, rc2;
  logic [15:0] seen, next_seen;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  always_comb begin
    next_seen = seen;
    if (sv2) begin
      next_seen = data_ready_pin_o ? 16'h0000 : seen + 16'h0001;
    end
    if (rc2 || !nrst_i) begin
      next_seen = 16'h0000;
    end
  end
  always_ff @(posedge clk_i) begin
    sv1  <= nrst_i & ce_i & sample_valid_i;
    sv2  <= nrst_i & sv1;
    rc1  <= reset_command_i;
    rc2  <= rc1;
    seen <= next_seen;
  end
  property p_dr_cause; data_ready_pin_o |-> sv2 && seen == decimation_value_i; endproperty
  a_dr_cause: assert property (p_dr_cause) else $error("update too early");
  property p_dr_due; sv2 && !rc2 && seen == decimation_value_i |-> data_ready_pin_o; endproperty
  a_dr_due: assert property (p_dr_due) else $error("update missing");
  property p_seen_max; seen <= decimation_value_i; endproperty
  a_seen_max: assert property (p_seen_max) else $error("too many samples");
  property p_dr_one; data_ready_pin_o && !sv1 |=> !data_ready_pin_o; endproperty
  a_dr_one: assert property (p_dr_one) else $error("data ready too long");
  property p_dr_gap; data_ready_pin_o && decimation_value_i != 16'h0000 |=> !data_ready_pin_o; endproperty
  a_dr_gap: assert property (p_dr_gap) else $error("updates too close");
  property p_rst_quiet; $rose(nrst_i) |-> !data_ready_pin_o && !miso_o ##1 !data_ready_pin_o; endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("outputs busy after reset");
  property p_miso_quiet; ($stable(sclk_i) && $stable(cs_n_i)) [*8] |-> $stable(miso_o); endproperty
  a_miso_quiet: assert property (p_miso_quiet) else $error("serial out moved");
  property p_dr_rate; data_ready_pin_o && decimation_value_i == 16'h0000 && sv1 |=> data_ready_pin_o; endproperty
  a_dr_rate: assert property (p_dr_rate) else $error("update rate low");
endmodule

// ===== iodr_host.sv
// Purpose: Host reading words over the serial port.
// Assumes: Mode 3 frames, MSB first, address in bits 14:8.
// Notes:   Phases are 9 and 5 clocks, above the 4 clock minimum.
`timescale 1ns/1ps
module iodr_host (
  input  wire logic clk_i,
  input  wire logic miso_i,
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      mosi_o
);
  // ****
  // Frame driver
  // ****
  initial begin
    sclk_o = 1'b1;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic xfer(input logic [6:0] addr, output logic [15:0] rd);
    logic [15:0] fr;
    fr = {1'b0, addr, 8'h00};
    cs_n_o = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      tick(9);
      rd[i] = miso_i;
      sclk_o = 1'b0;
      mosi_o = fr[i];
      tick(5);
      sclk_o = 1'b1;
    end
    tick(5);
    cs_n_o = 1'b1;
    // A released line must not keep its last level.
    mosi_o = ~mosi_o;
    tick(5);
  endtask
endmodule

// ===== iodr_output_regs_test.sv
// Purpose: Self-checking bench of the inertial output register block.
// Assumes: Clock enable high except in its own test; inputs move 1 ns after each edge.
// Notes:   The counter wrap takes most of the run.
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin n_errors++; \
$display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module iodr_output_regs_test
  import iodr_pkg::*;
;
  // ****
  // Bench
  // ****
  logic        clk_i, nrst_i, ce, sv, rcmd, sync, sclk, cs_n, mosi, miso, dr;
  logic [31:0] ax, ay, az, v;
  logic [31:0] g [3];
  logic [31:0] p [3];
  logic [32:0] s [3];
  logic [15:0] temp, dec, w;
  logic [2:0]  mode;
  int          n_errors = 0;
  int          checks_done = 0;
  int          cyc = 0;
  int          n_dr = 0;
  iodr_output_regs DUT (.clk_i, .nrst_i, .ce_i(ce), .sample_valid_i(sv), .accel_x_i(ax), .accel_y_i(ay),
    .accel_z_i(az), .gyro_x_i(g[0]), .gyro_y_i(g[1]), .gyro_z_i(g[2]), .temperature_i(temp),
    .decimation_value_i(dec), .sync_mode_i(mode), .reset_command_i(rcmd), .sync_pin_i(sync),
    .sclk_i(sclk), .cs_n_i(cs_n), .mosi_i(mosi), .miso_o(miso), .data_ready_pin_o(dr));
  iodr_host host (.clk_i, .miso_i(miso), .sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi));
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic samp(input logic [31:0] val);
    for (int k = 0; k < 3; k++) begin
      g[k] = val + 32'(k) * 32'h0100_0003;
      s[k] = s[k] + {g[k][31], g[k]} + {p[k][31], p[k]};
      p[k] = g[k];
    end
    sv = 1'b1;
    tick(1);
    sv = 1'b0;
    tick(3);
  endtask
  // The word asked for comes back one frame later, so three frames give a pair.
  task automatic get(input logic [6:0] a, output logic [31:0] r);
    host.xfer(a, w);
    host.xfer(a + OFS_HIGH_STEP, r[15:0]);
    host.xfer(a, r[31:16]);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc++;
    if (dr === 1'b1) begin
      n_dr++;
    end
    if (cyc == 95000) begin
      n_errors++;
      wrap_up();
    end
  end
  initial begin
    {nrst_i, sv, rcmd, sync, dec, mode} = '0;
    ce = 1'b1;
    ax = 32'h8300_1234;
    ay = 32'h7d00_abcd;
    az = 32'hffff_fffe;
    temp = 16'hff06;
    for (int k = 0; k < 3; k++) begin
      {g[k], p[k], s[k]} = '0;
    end
    tick(10);
    nrst_i = 1'b1;
    tick(4);
    get(7'h20, v);
    `CHK(v, 32'h0000_0000)
    $display("test reset done");
    samp(32'hfff0_0010);
    get(OFS_ACCEL_X_LOW, v);
    `CHK(v, ax)
    // Above the map: must read zero, not alias onto the x accel words.
    get(7'h50, v);
    `CHK(v, 32'h0000_0000)
    get(OFS_ACCEL_Y_LOW, v);
    `CHK(v, ay)
    get(OFS_ACCEL_Z_LOW, v);
    `CHK(v, az)
    get(OFS_TEMPERATURE, v);
    `CHK(v, {16'h0000, temp})
    get(7'h20, v);
    `CHK(v[31:16], 16'h0001)
    for (int k = 0; k < 3; k++) begin
      get(OFS_DANGLE_X_LOW + 7'(k) * OFS_DANGLE_STRIDE, v);
      `CHK(v, s[k][32:1])
      s[k] = '0;
    end
    $display("test single update done");
    dec = 16'h0002;
    ay = 32'h0123_4567;
    samp(32'h8000_0001);
    samp(32'h7fff_fff0);
    samp(32'h0000_0031);
    get(7'h20, v);
    `CHK(v[31:16], 16'h0002)
    get(OFS_DANGLE_X_LOW, v);
    `CHK(v, s[0][32:1])
    get(OFS_ACCEL_Y_LOW, v);
    `CHK(v, ay)
    $display("test decimation done");
    dec = 16'h0000;
    mode = SYNC_MODE_SCALED;
    sync = 1'b1;
    tick(4);
    sync = 1'b0;
    tick(3 * TS_LSB_CYCLES + TS_LSB_CYCLES / 2);
    samp(32'h0000_0100);
    get(OFS_TEMPERATURE, v);
    `CHK(v[31:16], 16'h0003)
    $display("test time stamp done");
    mode = 3'b000;
    rcmd = 1'b1;
    tick(1);
    rcmd = 1'b0;
    tick(2);
    samp(32'h0000_0200);
    get(OFS_TEMPERATURE, v);
    `CHK(v[31:16], 16'h0000)
    get(7'h20, v);
    `CHK(v[31:16], 16'h0001)
    $display("test reset command done");
    ce = 1'b0;
    sv = 1'b1;
    tick(2);
    ce = 1'b1;
    sv = 1'b0;
    tick(3);
    get(7'h20, v);
    `CHK(v[31:16], 16'h0001)
    $display("test clock enable done");
    n_dr = 0;
    sv = 1'b1;
    tick(65534);
    sv = 1'b0;
    tick(3);
    `CHK(n_dr, 65534)
    get(7'h20, v);
    `CHK(v[31:16], 16'hffff)
    samp(32'h0000_0300);
    get(7'h20, v);
    `CHK(v[31:16], 16'h0000)
    $display("test counter wrap done");
    wrap_up();
  end
endmodule
bind iodr_output_regs iodr_props u_props (.clk_i, .nrst_i, .ce_i, .sample_valid_i, .decimation_value_i,
  .reset_command_i, .sclk_i, .cs_n_i, .miso_o, .data_ready_pin_o);
